/* rtl/qbx_cfg.svh */
// Constants for the quasi-bidirectional port expander.
// Operation
// RULE_01: Wrap identification bytes until master not-acknowledges.
// RULE_02: Not-acknowledge ends identification read, release data.
// RULE_03: Master: F8h, address, repeated start, F9h.
// RULE_04: No direction register; reads return live pins.
// RULE_05: Eight independent bits, written and read together.
// RULE_06: Zero bit keeps strong sink on continuously.
// RULE_07: Written one pulses strong pull-up during acknowledge.
// RULE_08: Write byte MSB first, applied after acknowledge.
// RULE_09: Any number of bytes; each replaces latch.
// RULE_10: Master writes one to input pins.
// RULE_11: Read sends port byte; acknowledge gives resample.
// RULE_12: Stop mid-byte keeps latch, discards partial byte.
// RULE_13: Every reset sets all latch bits to one.
// RULE_14: Power-on reset initialises latch and bus machine.
// RULE_15: Reset pin low holds defaults until high.
// RULE_16: Data edges while clock high are start, stop.
// RULE_17: Data stable while clock high, bit per pulse.
// RULE_18: Master starts only when bus idle.
// RULE_19: General call then 06h then stop resets.
// RULE_20: Identification: 12-bit maker, 9-bit part, 3-bit revision.
// RULE_21: Identification address byte matched ignoring its LSB.
// RULE_22: Synchronise bus and pins; sample pins at acknowledge.
// RULE_23: Separate sink, weak, strong outputs; never sink with strong.
`ifndef QBX_CFG_SVH
`define QBX_CFG_SVH
`define QBX_GCALL_ADDR  8'h00
`define QBX_SWRST_BYTE  8'h06
`define QBX_ID_WR_ADDR  8'hF8
`define QBX_ID_RD_ADDR  8'hF9
`define QBX_LATCH_RST   8'hFF
`define QBX_ID_LAST     2'h2
`define QBX_BIT_LAST    3'h7
`endif

/* rtl/qbx_pkg.sv */
// Types for the quasi-bidirectional port expander.
package qbx_pkg;
  typedef enum logic [6:0] {
    QBX_IDLE  = 7'h01,
    QBX_ADDR  = 7'h02,
    QBX_AACK  = 7'h04,
    QBX_WRX   = 7'h08,
    QBX_WACK  = 7'h10,
    QBX_TX    = 7'h20,
    QBX_MACK  = 7'h40
  } qbx_state_t;
  typedef enum logic [2:0] {
    QBX_M_PORT = 3'h1,
    QBX_M_GC   = 3'h2,
    QBX_M_IDW  = 3'h4
  } qbx_mode_t;
  typedef struct packed {
    logic [7:0] sink_en;
    logic [7:0] weak_en;
    logic [7:0] strong_en;
  } qbx_drive_t;
endpackage

/* rtl/qbx_expander.sv */
// Bus slave and port logic of the quasi-bidirectional port expander.
`timescale 1ns/10ps
`include "qbx_cfg.svh"
module qbx_expander
  import qbx_pkg::*;
#(
  parameter logic [6:0]  OWN_ADDR = 7'h20,
  parameter logic [11:0] ID_MAKER = 12'h5A5,  // Arbitrary value.
  parameter logic [8:0]  ID_PART  = 9'h0C3,   // Arbitrary value.
  parameter logic [2:0]  ID_REV   = 3'h1      // Arbitrary value.
) (
  // Clock, reset, enable
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       rst_pin_n,
  // Bus lines
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe_n,
  // Port pins
  input  wire logic [7:0] port_pin_in,
  output qbx_drive_t      drive
);
  logic [1:0] scl_s, sda_s, rstp_s;
  logic [7:0] pin_s1, pin_s2;
  logic       scl_d, sda_d;
  qbx_state_t state_r;
  qbx_mode_t  mode_r;
  logic [7:0] shift_r, tx_r, latch_r;
  logic [2:0] bit_r;
  logic [1:0] id_idx_r;
  logic       rd_r, id_ok_r, swrst_arm_r, ack_drv_r, pulse_r, byte_done_r;
  logic [7:0] strong_r;
  logic       scl_rise, scl_fall, start_c, stop_c, hold_rst;
  logic [7:0] rx_byte;
  logic [23:0] id_word;

  // Synchronisers; logic reads the second stage and the delayed SCL/SDA copies, never the first stage. [RULE_22]
  always_ff @(posedge clock) begin
    if (ce) begin
      scl_s  <= {scl_s[0], scl_in};
      sda_s  <= {sda_s[0], sda_in};
      rstp_s <= {rstp_s[0], rst_pin_n};
      pin_s1 <= port_pin_in;
      pin_s2 <= pin_s1;
      scl_d  <= scl_s[1];
      sda_d  <= sda_s[1];
    end
  end

  assign scl_rise = scl_s[1] & ~scl_d;
  assign scl_fall = ~scl_s[1] & scl_d;
  assign start_c  = scl_s[1] & scl_d & sda_d & ~sda_s[1];  // [RULE_16]
  assign stop_c   = scl_s[1] & scl_d & ~sda_d & sda_s[1];  // [RULE_16]
  assign rx_byte  = {shift_r[6:0], sda_s[1]};
  assign id_word  = {ID_MAKER, ID_PART, ID_REV};  // [RULE_20]
  // The pin reset is synchronous to keep a single reset style; it holds while low.
  assign hold_rst = srst | ~rstp_s[1];  // [RULE_14] [RULE_15]

  function automatic logic [7:0] id_byte(input logic [1:0] idx, input logic [23:0] w);
    logic [7:0] b;
    b = w[7:0];
    unique case (idx)
      2'h0:    b = w[23:16];
      2'h1:    b = w[15:8];
      default: b = w[7:0];
    endcase
    return b;
  endfunction

  // Bus state machine; bits are taken on SCL rise, SDA changed on SCL fall. [RULE_17]
  always_ff @(posedge clock) begin
    if (hold_rst) begin
      state_r     <= QBX_IDLE;
      mode_r      <= QBX_M_PORT;
      shift_r     <= 8'h00;
      tx_r        <= 8'h00;
      bit_r       <= 3'h0;
      byte_done_r <= 1'b0;
      id_idx_r    <= 2'h0;
      rd_r        <= 1'b0;
      id_ok_r     <= 1'b0;
      swrst_arm_r <= 1'b0;
      ack_drv_r   <= 1'b0;
      latch_r     <= `QBX_LATCH_RST;  // [RULE_13]
      pulse_r     <= 1'b0;
      strong_r    <= 8'h00;
    end else if (ce) begin
      if (stop_c) begin
        // A partial byte is simply dropped; the latch keeps its last acknowledged value.
        state_r   <= QBX_IDLE;  // [RULE_12]
        ack_drv_r <= 1'b0;
        // A stop may arrive while the clock is high, so the strong pulse ends here too.
        strong_r    <= 8'h00;
        pulse_r     <= 1'b0;
        byte_done_r <= 1'b0;
        id_ok_r   <= 1'b0;
        if (swrst_arm_r) begin
          latch_r <= `QBX_LATCH_RST;  // [RULE_19] [RULE_13]
        end
        swrst_arm_r <= 1'b0;
      end else if (start_c) begin
        // A repeated start cancels a pending software reset. [RULE_19]
        state_r     <= QBX_ADDR;
        bit_r       <= 3'h0;
        byte_done_r <= 1'b0;
        ack_drv_r   <= 1'b0;
        swrst_arm_r <= 1'b0;
      end else begin
        if (scl_rise && pulse_r) begin
          strong_r <= latch_r;  // [RULE_07]
        end
        if (scl_fall && pulse_r) begin
          strong_r <= 8'h00;  // [RULE_07]
          pulse_r  <= 1'b0;
        end
        unique case (state_r)
          QBX_IDLE: begin
            ack_drv_r <= 1'b0;
          end
          QBX_ADDR, QBX_WRX: begin
            // The fall that ends a start also finds bit_r at zero, so a flag marks a full byte.
            if (scl_rise) begin
              shift_r     <= rx_byte;
              bit_r       <= bit_r + 3'h1;
              byte_done_r <= (bit_r == `QBX_BIT_LAST);
            end
            if (scl_fall && byte_done_r) begin
              // Eight bits held; decide the acknowledge now.
              byte_done_r <= 1'b0;
              if (state_r == QBX_ADDR) begin
                rd_r <= shift_r[0];
                if (shift_r[7:1] == OWN_ADDR) begin
                  mode_r <= QBX_M_PORT;
                  id_ok_r <= 1'b0;
                  ack_drv_r <= 1'b1;
                  state_r <= QBX_AACK;
                end else if (shift_r == `QBX_GCALL_ADDR) begin
                  mode_r <= QBX_M_GC;
                  id_ok_r <= 1'b0;
                  ack_drv_r <= 1'b1;
                  state_r <= QBX_AACK;
                end else if (shift_r == `QBX_ID_WR_ADDR) begin
                  mode_r <= QBX_M_IDW;
                  ack_drv_r <= 1'b1;
                  state_r <= QBX_AACK;
                end else if (shift_r == `QBX_ID_RD_ADDR && id_ok_r) begin
                  id_idx_r <= 2'h0;
                  ack_drv_r <= 1'b1;
                  tx_r <= id_byte(2'h0, id_word);
                  state_r <= QBX_AACK;
                end else begin
                  state_r <= QBX_IDLE;
                  id_ok_r <= 1'b0;
                end
              end else begin
                unique case (mode_r)
                  QBX_M_PORT: begin
                    latch_r <= shift_r;  // [RULE_05] [RULE_08] [RULE_09]
                    pulse_r <= 1'b1;  // [RULE_07]
                    ack_drv_r <= 1'b1;
                    state_r <= QBX_WACK;
                  end
                  QBX_M_GC: begin
                    ack_drv_r <= (shift_r == `QBX_SWRST_BYTE) & ~swrst_arm_r;
                    swrst_arm_r <= (shift_r == `QBX_SWRST_BYTE) & ~swrst_arm_r;
                    state_r <= ((shift_r == `QBX_SWRST_BYTE) & ~swrst_arm_r) ? QBX_WACK
                                                                              : QBX_IDLE;
                  end
                  default: begin
                    ack_drv_r <= (shift_r[7:1] == OWN_ADDR);  // [RULE_21]
                    id_ok_r   <= (shift_r[7:1] == OWN_ADDR);
                    state_r   <= (shift_r[7:1] == OWN_ADDR) ? QBX_WACK : QBX_IDLE;
                  end
                endcase
              end
            end
          end
          QBX_AACK, QBX_WACK: begin
            if (scl_rise && state_r == QBX_AACK && rd_r && !id_ok_r) begin
              tx_r <= pin_s2;  // [RULE_04] [RULE_22] [RULE_11]
            end
            if (scl_fall) begin
              bit_r <= 3'h0;
              if (rd_r && state_r == QBX_AACK) begin
                ack_drv_r <= ~tx_r[7];
                state_r <= QBX_TX;
              end else begin
                ack_drv_r <= 1'b0;
                state_r <= QBX_WRX;
              end
            end
          end
          QBX_TX: begin
            if (scl_fall) begin
              bit_r <= bit_r + 3'h1;
              if (bit_r == `QBX_BIT_LAST) begin
                ack_drv_r <= 1'b0;
                state_r <= QBX_MACK;
              end else begin
                ack_drv_r <= ~tx_r[3'h6 - bit_r];
              end
            end
          end
          QBX_MACK: begin
            if (scl_rise) begin
              if (sda_s[1]) begin
                state_r <= QBX_IDLE;  // [RULE_02] [RULE_11]
                id_ok_r <= 1'b0;
              end else if (id_ok_r) begin
                id_idx_r <= (id_idx_r == `QBX_ID_LAST) ? 2'h0 : id_idx_r + 2'h1;  // [RULE_01]
                tx_r <= id_byte((id_idx_r == `QBX_ID_LAST) ? 2'h0 : id_idx_r + 2'h1,
                                id_word);
              end else begin
                tx_r <= pin_s2;  // [RULE_11]
              end
            end
            if (scl_fall && state_r == QBX_MACK) begin
              bit_r <= 3'h0;
              ack_drv_r <= ~tx_r[7];
              state_r <= QBX_TX;
            end
          end
          default: state_r <= QBX_IDLE;
        endcase
      end
    end
  end

  assign sda_oe_n = ~ack_drv_r;
  // Sink and strong pull-up use complementary latch bits, so they never overlap.
  assign drive.sink_en   = ~latch_r;  // [RULE_06] [RULE_23]
  assign drive.weak_en   = latch_r;
  assign drive.strong_en = strong_r & latch_r;  // [RULE_23]
endmodule

/* sim/qbx_expander_sva.sv */
// Port-level assertions for the port expander.
`timescale 1ns/10ps
module qbx_expander_sva
  import qbx_pkg::*;
(
  // Clock and resets
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       rst_pin_n,
  // Bus and pins
  input wire logic       scl_in,
  input wire logic       sda_oe_n,
  input wire qbx_drive_t drive
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // A sink may only switch on an acknowledged write or on a reset to all inputs.
  property p_sink;
    $changed(drive.sink_en) |-> !sda_oe_n || drive.sink_en == 8'h00;
  endproperty
  a_sink: assert property (p_sink) else $error("sink moved outside write ack");
  property p_clash; (drive.sink_en & drive.strong_en) == 8'h00; endproperty
  a_clash: assert property (p_clash) else $error("sink with strong");
  property p_rst;
    disable iff (1'b0) srst |=> drive.weak_en == 8'hFF && sda_oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  property p_pin; (!rst_pin_n)[*5] |-> drive.weak_en == 8'hFF && sda_oe_n; endproperty
  a_pin: assert property (p_pin) else $error("pin reset");
  property p_sfall; $fell(scl_in) |-> ##5 drive.strong_en == 8'h00; endproperty
  a_sfall: assert property (p_sfall) else $error("strong after clock low");
  property p_srise; $rose(|drive.strong_en) |-> $past(scl_in, 2); endproperty
  a_srise: assert property (p_srise) else $error("strong outside high");
  property p_latch;
    $changed(drive.weak_en) && drive.weak_en != 8'hFF |-> !$past(scl_in, 2);
  endproperty
  a_latch: assert property (p_latch) else $error("latch moved in high");
  property p_oe; $changed(sda_oe_n) |-> !$past(scl_in, 2); endproperty
  a_oe: assert property (p_oe) else $error("data moved in high");
  c_strong: cover property (|drive.strong_en);
  c_ack: cover property (!sda_oe_n);
  c_pin: cover property ((!rst_pin_n)[*5]);
endmodule
bind qbx_expander qbx_expander_sva i_sva (.clock(clock), .srst(srst), .rst_pin_n(rst_pin_n),
  .scl_in(scl_in), .sda_oe_n(sda_oe_n), .drive(drive));

/* sim/qbx_bus_master.sv */
// Bus master model driving clock and data at 320 ns per bit.
`timescale 1ns/10ps
module qbx_bus_master (
  // Bus lines
  output logic     scl,
  output logic     sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves mid low phase only.
  task automatic bit_o(input logic b);
    #80 sda_low = !b;
    #80 scl = 1'b1;
    #160 scl = 1'b0;
  endtask
  task automatic bit_i(output logic b);
    #80 sda_low = 1'b0;
    #80 scl = 1'b1;
    #80 b = sda;
    #80 scl = 1'b0;
  endtask
  // Also used as repeated start.
  task automatic start();
    #80 sda_low = 1'b0;
    #80 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic stop();
    #80 sda_low = 1'b1;
    #80 scl = 1'b1;
    #80 sda_low = 1'b0;
    #80;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_o(d[i]);
    bit_i(b);
    ack = !b;
  endtask
  task automatic rd(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_i(d[i]);
    bit_o(!ack);
  endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the port expander.
`timescale 1ns/10ps
module tb_top;
  import qbx_pkg::*;
  localparam logic [11:0] MKR = 12'h3C7; // Arbitrary value.
  localparam logic [8:0]  PRT = 9'h11A;  // Arbitrary value.
  localparam logic [2:0]  REV = 3'h5;    // Arbitrary value.
  localparam logic [6:0]  ADR = 7'h2B;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic       rst_pin_n = 1'b1;
  logic [7:0] ext = 8'hFF;
  logic       scl;
  logic       sda_low;
  logic       sda_oe_n;
  wire        sda = !sda_low && sda_oe_n;
  qbx_drive_t drive;
  int         error_cnt = 0;
  int         check_count = 0;
  int         cyc = 0;
  logic       ack;
  logic [7:0] d;
  logic [7:0] stg = 8'h00;
  always #20 clock = !clock;
  always @(posedge clock) stg <= stg | drive.strong_en;
  qbx_expander #(.OWN_ADDR(ADR), .ID_MAKER(MKR), .ID_PART(PRT), .ID_REV(REV)) i_dut (
    .clock(clock), .srst(srst), .ce(1'b1), .rst_pin_n(rst_pin_n), .scl_in(scl),
    .sda_in(sda), .sda_oe_n(sda_oe_n), .port_pin_in(ext & ~drive.sink_en), .drive(drive));
  qbx_bus_master i_mst (.scl(scl), .sda_low(sda_low), .sda(sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic wr_port(input logic [7:0] v);
    i_mst.start();
    i_mst.wr({ADR, 1'b0}, ack);
    chk({7'h00, ack}, 8'h01);
    stg = 8'h00;
    i_mst.wr(v, ack);
  endtask
  task automatic t_write();
    wr_port(8'hA3);
    chk(drive.weak_en, 8'hA3);
    chk(stg, 8'hA3);
    i_mst.wr(8'h5C, ack);
    chk(drive.sink_en, 8'hA3);
    i_mst.stop();
    $display("write test done");
  endtask
  task automatic t_read();
    ext = 8'h96;
    i_mst.start();
    i_mst.wr({ADR, 1'b1}, ack);
    fork
      #2560 ext = 8'h3C;
    join_none
    i_mst.rd(1'b1, d);
    chk(d, 8'h14);
    i_mst.rd(1'b0, d);
    chk(d, 8'h1C);
    i_mst.stop();
    i_mst.start();
    i_mst.wr({ADR, 1'b0}, ack);
    for (int i = 0; i < 4; i++) i_mst.bit_o(1'b1);
    i_mst.stop();
    chk(drive.weak_en, 8'h5C);
    $display("read test done");
  endtask
  task automatic t_id();
    logic [23:0] id;
    id = {MKR, PRT, REV};
    i_mst.start();
    i_mst.wr(8'hF8, ack);
    i_mst.wr({ADR, 1'b1}, ack);
    chk({7'h00, ack}, 8'h01);
    i_mst.start();
    i_mst.wr(8'hF9, ack);
    for (int i = 0; i < 4; i++) begin
      i_mst.rd(i < 3, d);
      chk(d, id[23 - 8 * (i % 3) -: 8]);
    end
    repeat (4) @(negedge clock);
    chk({7'h00, sda_oe_n}, 8'h01);
    i_mst.stop();
    $display("id test done");
  endtask
  task automatic t_resets();
    i_mst.start();
    i_mst.wr(8'h00, ack);
    i_mst.wr(8'h06, ack);
    chk({7'h00, ack}, 8'h01);
    i_mst.stop();
    repeat (6) @(negedge clock);
    chk(drive.weak_en, 8'hFF);
    wr_port(8'h00);
    i_mst.stop();
    chk(drive.sink_en, 8'hFF);
    i_mst.start();
    i_mst.wr(8'h00, ack);
    i_mst.wr(8'h06, ack);
    i_mst.start();
    i_mst.stop();
    repeat (6) @(negedge clock);
    chk(drive.sink_en, 8'hFF);
    rst_pin_n = 1'b0;
    repeat (10) @(negedge clock);
    chk(drive.sink_en, 8'h00);
    rst_pin_n = 1'b1;
    repeat (6) @(negedge clock);
    $display("reset test done");
  endtask
  initial begin
    repeat (20) @(negedge clock);
    srst = 1'b0;
    chk(drive.weak_en, 8'hFF);
    repeat (5) @(negedge clock);
    t_write();
    t_read();
    t_id();
    t_resets();
    complete_run();
  end
endmodule
